/* File: tsb_fifo.sv */
// response fifo with valid and ready on both sides
`timescale 1ns/1ns
module tsb_fifo #(
   parameter int WIDTH = 85,
   parameter int DEPTH = 4
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W+1)'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] store_r [DEPTH];
   logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
   logic [PTR_W:0] count_r, count_nxt;
   logic push, pop;

   assign in_ready = (count_r != DEPTH_CNT);
   assign out_valid = (count_r != '0);
   assign out_data = store_r[rd_ptr_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      count_nxt = count_r;
      if (push) begin
         wr_ptr_nxt = (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
         rd_ptr_nxt = (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
         count_nxt = count_r + 1'b1;
      end else if (pop && !push) begin
         count_nxt = count_r - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r <= count_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         store_r[wr_ptr_r] <= in_data;
      end
   end
endmodule // tsb_fifo

/* File: tsb_master_model.sv */
// master model for the tagged split transaction bus
`timescale 1ns/1ns
module tsb_master_model
(
   input wire logic ref_clk,
   output logic txn_valid,
   output logic op_type_alt,
   output logic [tsb_pkg::ADDR_W-1:0] address,
   output logic [tsb_pkg::BE_W-1:0] byte_lane_enables_n,
   output logic [tsb_pkg::TAG_W-1:0] request_tag,
   output logic [tsb_pkg::DATA_W-1:0] write_data,
   input wire logic txn_accept,
   input wire logic read_data_valid,
   input wire logic [tsb_pkg::TAG_W-1:0] response_tag,
   input wire logic [tsb_pkg::DATA_W-1:0] read_data
);
   import tsb_pkg::*;
   int cyc = 0;
   int take_cyc = 0;
   int refused = 0;
   logic [TAG_W-1:0] tag_q[$];
   int resp_cyc[$];
   logic [DATA_W-1:0] got[logic [TAG_W-1:0]];
   initial begin
      txn_valid = 1'b0;
      op_type_alt = OP_WRITE;
      address = '0;
      byte_lane_enables_n = 8'hff;
      request_tag = '0;
      write_data = '0;
   end
   // no backpressure on returns, data filed by tag
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (read_data_valid === 1'b1) begin
         got[response_tag] = read_data;
         tag_q.push_back(response_tag);
         resp_cyc.push_back(cyc);
      end
   end
   task automatic issue(input logic op, input logic [ADDR_W-1:0] a,
         input logic [BE_W-1:0] be_n, input logic [TAG_W-1:0] t,
         input logic [DATA_W-1:0] d);
      bit ok;
      txn_valid = 1'b1;
      op_type_alt = op;
      address = a;
      byte_lane_enables_n = be_n;
      request_tag = t;
      write_data = d;
      ok = 1'b0;
      while (!ok) begin
         #(CLK_PERIOD_NS - 2);
         ok = (txn_accept === 1'b1);
         if (!ok) refused++;
         @(posedge ref_clk);
         #1;
      end
      take_cyc = cyc - 1;
   endtask
   // released lines show inverted garbage
   task automatic release_bus();
      txn_valid = 1'b0;
      op_type_alt = ~op_type_alt;
      address = ~address;
      byte_lane_enables_n = ~byte_lane_enables_n;
      request_tag = ~request_tag;
      write_data = ~write_data;
      @(posedge ref_clk);
      #1;
   endtask
endmodule // tsb_master_model

/* File: tsb_pkg.sv */
// shared constants for the tagged split transaction slave
package tsb_pkg;
   localparam int ADDR_W = 45;
   localparam int DATA_W = 64;
   localparam int BE_W = 8;
   localparam int TAG_W = 21;
   localparam int RESP_W = TAG_W + DATA_W;
   localparam int WORD_LSB = 3;
   localparam int IDX_W = 5;
   localparam int MEM_WORDS = 32;
   localparam int SLOW_BIT = 8;
   localparam int FIFO_DEPTH = 4;
   localparam int CLK_PERIOD_NS = 50;
   localparam int SLOW_TIME_NS = 150;
   localparam int SLOW_CYCLES = (SLOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OUTSTANDING_MAX = 6;
   localparam logic OP_WRITE = 1'b0;
   localparam logic OP_READ = 1'b1;
   localparam logic [1:0] SLOT_CNT_RESET = 2'h0;
   localparam logic [2:0] OUT_CNT_RESET = 3'h0;
   localparam logic [TAG_W-1:0] TAG_RESET = 21'h0;
   localparam logic [DATA_W-1:0] DATA_RESET = 64'h0;
   typedef enum logic [1:0] {
      SLOT_IDLE = 2'b00,
      SLOT_WAIT = 2'b01,
      SLOT_READY = 2'b10
   } tsb_slot_e;
endpackage

/* File: tsb_slave.sv */
// memory slave on the tagged split transaction bus
`timescale 1ns/1ns
module tsb_slave (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic txn_valid,
   input wire logic op_type_alt,
   input wire logic [tsb_pkg::ADDR_W-1:0] address,
   input wire logic [tsb_pkg::BE_W-1:0] byte_lane_enables_n,
   input wire logic [tsb_pkg::TAG_W-1:0] request_tag,
   input wire logic [tsb_pkg::DATA_W-1:0] write_data,
   output logic txn_accept,
   output logic read_data_valid,
   output logic [tsb_pkg::TAG_W-1:0] response_tag,
   output logic [tsb_pkg::DATA_W-1:0] read_data
);
   import tsb_pkg::*;

   // address decode
   logic [IDX_W-1:0] word_idx;
   logic is_read, is_slow;
   logic [DATA_W-1:0] mem_word;

   assign word_idx = address[WORD_LSB +: IDX_W];
   assign is_read = (op_type_alt == OP_READ);
   assign is_slow = address[SLOW_BIT];

   // storage, one array per byte lane; enables are active low
   logic take, take_wr, take_fast, take_slow;

   genvar g;
   generate
      for (g = 0; g < BE_W; g++) begin : g_lane
         logic [7:0] lane_r [MEM_WORDS];
         always_ff @(posedge ref_clk) begin
            if (take_wr && !byte_lane_enables_n[g]) begin
               lane_r[word_idx] <= write_data[g*8 +: 8];
            end
         end
         assign mem_word[g*8 +: 8] = lane_r[word_idx];
      end
   endgenerate

   // fast read stage
   logic s1_valid_r, s1_valid_nxt;
   logic [TAG_W-1:0] s1_tag_r, s1_tag_nxt;
   logic [DATA_W-1:0] s1_data_r, s1_data_nxt;

   // slow read slot, answers later so responses can pass each other
   tsb_slot_e slot_state_r, slot_state_nxt;
   logic [1:0] slot_cnt_r, slot_cnt_nxt;
   logic [TAG_W-1:0] slot_tag_r, slot_tag_nxt;
   logic [DATA_W-1:0] slot_data_r, slot_data_nxt;

   // fifo hookup and return pacing
   logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [RESP_W-1:0] fifo_in_data, fifo_out_data;
   logic slot_push, s1_push, s1_free, pop;
   logic ret_gap_r, ret_gap_nxt;

   // output registers
   logic rdv_r, rdv_nxt;
   logic [TAG_W-1:0] rtag_r, rtag_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;

   // handshake
   assign slot_push = (slot_state_r == SLOT_READY) && fifo_in_ready;
   assign s1_push = s1_valid_r && (slot_state_r != SLOT_READY) && fifo_in_ready;
   assign s1_free = !s1_valid_r || s1_push;
   // stall when the fast stage is full and cannot move into the fifo, or when a slow read finds the slow slot taken
   assign txn_accept = s1_free
      && !(is_read && is_slow && (slot_state_r != SLOT_IDLE));
   assign take = txn_valid && txn_accept;
   assign take_wr = take && !is_read;
   assign take_fast = take && is_read && !is_slow;
   assign take_slow = take && is_read && is_slow;

   always_comb begin
      s1_valid_nxt = s1_valid_r;
      s1_tag_nxt = s1_tag_r;
      s1_data_nxt = s1_data_r;
      if (s1_push) begin
         s1_valid_nxt = 1'b0;
      end
      if (take_fast) begin
         s1_valid_nxt = 1'b1;
         s1_tag_nxt = request_tag;
         s1_data_nxt = mem_word;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s1_valid_r <= 1'b0;
         s1_tag_r <= TAG_RESET;
         s1_data_r <= DATA_RESET;
      end else begin
         s1_valid_r <= s1_valid_nxt;
         s1_tag_r <= s1_tag_nxt;
         s1_data_r <= s1_data_nxt;
      end
   end

   always_comb begin
      slot_state_nxt = slot_state_r;
      slot_cnt_nxt = slot_cnt_r;
      slot_tag_nxt = slot_tag_r;
      slot_data_nxt = slot_data_r;
      unique case (slot_state_r)
         SLOT_IDLE: begin
            if (take_slow) begin
               slot_state_nxt = SLOT_WAIT;
               slot_cnt_nxt = 2'(SLOW_CYCLES - 1);
               slot_tag_nxt = request_tag;
               slot_data_nxt = mem_word;
            end
         end
         SLOT_WAIT: begin
            if (slot_cnt_r == 2'h1) begin
               slot_state_nxt = SLOT_READY;
            end
            slot_cnt_nxt = slot_cnt_r - 2'h1;
         end
         SLOT_READY: begin
            if (slot_push) begin
               slot_state_nxt = SLOT_IDLE;
            end
         end
         default: begin
            slot_state_nxt = SLOT_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         slot_state_r <= SLOT_IDLE;
         slot_cnt_r <= SLOT_CNT_RESET;
         slot_tag_r <= TAG_RESET;
         slot_data_r <= DATA_RESET;
      end else begin
         slot_state_r <= slot_state_nxt;
         slot_cnt_r <= slot_cnt_nxt;
         slot_tag_r <= slot_tag_nxt;
         slot_data_r <= slot_data_nxt;
      end
   end

   // slow slot wins the fifo input; the fast stage waits
   assign fifo_in_valid = (slot_state_r == SLOT_READY) || s1_valid_r;
   assign fifo_in_data = (slot_state_r == SLOT_READY) ? {slot_tag_r, slot_data_r}
                                                       : {s1_tag_r, s1_data_r};
   // return path delivers at most every other cycle
   assign fifo_out_ready = !ret_gap_r;
   assign pop = fifo_out_valid && fifo_out_ready;

   tsb_fifo #(
      .WIDTH(RESP_W),
      .DEPTH(FIFO_DEPTH)
   ) tsb_fifo_i (
      .ref_clk(ref_clk),
      .reset(reset),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   always_comb begin
      ret_gap_nxt = pop;
      rdv_nxt = pop;
      rtag_nxt = rtag_r;
      rdata_nxt = rdata_r;
      if (pop) begin
         rtag_nxt = fifo_out_data[RESP_W-1 -: TAG_W];
         rdata_nxt = fifo_out_data[DATA_W-1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ret_gap_r <= 1'b0;
         rdv_r <= 1'b0;
         rtag_r <= TAG_RESET;
         rdata_r <= DATA_RESET;
      end else begin
         ret_gap_r <= ret_gap_nxt;
         rdv_r <= rdv_nxt;
         rtag_r <= rtag_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // return path carries only read answers
   assign read_data_valid = rdv_r;
   assign response_tag = rtag_r;
   assign read_data = rdata_r;

   // checking helpers: reads in flight
   logic [2:0] out_cnt_r, out_cnt_nxt;
   always_comb begin
      out_cnt_nxt = out_cnt_r;
      if ((take_fast || take_slow) && !rdv_r) begin
         out_cnt_nxt = out_cnt_r + 3'h1;
      end else if (!(take_fast || take_slow) && rdv_r) begin
         out_cnt_nxt = out_cnt_r - 3'h1;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         out_cnt_r <= OUT_CNT_RESET;
      end else begin
         out_cnt_r <= out_cnt_nxt;
      end
   end

   sequence seq_slow_taken;
      txn_valid && txn_accept && is_read && is_slow;
   endsequence
   sequence seq_slot_busy;
      (slot_state_r != SLOT_IDLE) [*3];
   endsequence

   AST_OUTSTANDING_BOUND: assert property (@(posedge ref_clk) disable iff (reset)
      out_cnt_r <= 3'(OUTSTANDING_MAX))
      else $error("too many reads in flight");

   AST_VALID_NEEDS_READ: assert property (@(posedge ref_clk) disable iff (reset)
      read_data_valid |-> out_cnt_r != 3'h0)
      else $error("read data valid without a pending read");

   AST_WRITE_STORES: assert property (@(posedge ref_clk) disable iff (reset)
      (take_wr && byte_lane_enables_n == 8'h00) ##1 (word_idx == $past(word_idx))
      |-> mem_word == $past(write_data))
      else $error("full write not stored");

   AST_READ_KEEPS_MEM: assert property (@(posedge ref_clk) disable iff (reset)
      (take && is_read) ##1 (word_idx == $past(word_idx)) |-> $stable(mem_word))
      else $error("read changed memory");

   AST_REFUSED_KEEPS_MEM: assert property (@(posedge ref_clk) disable iff (reset)
      (txn_valid && !txn_accept) ##1 (word_idx == $past(word_idx)) |-> $stable(mem_word))
      else $error("refused transaction had effect");

   AST_IDLE_IGNORED: assert property (@(posedge ref_clk) disable iff (reset)
      (!txn_valid && !s1_valid_r && slot_state_r == SLOT_IDLE)
      |=> !s1_valid_r && slot_state_r == SLOT_IDLE)
      else $error("empty cycle started a read");

   AST_FAST_TAKEN: assert property (@(posedge ref_clk) disable iff (reset)
      take_fast |=> s1_valid_r && s1_tag_r == $past(request_tag))
      else $error("accepted read not taken");

   AST_SLOW_HELD: assert property (@(posedge ref_clk) disable iff (reset)
      seq_slow_taken |=> seq_slot_busy)
      else $error("slow read answered too early");

   AST_SLOW_NO_DOUBLE: assert property (@(posedge ref_clk) disable iff (reset)
      (slot_state_r != SLOT_IDLE && txn_valid && is_read && is_slow) |-> !txn_accept)
      else $error("second slow read accepted");

   AST_TAG_WITH_DATA: assert property (@(posedge ref_clk) disable iff (reset)
      pop |=> read_data_valid
         && response_tag == $past(fifo_out_data[RESP_W-1 -: TAG_W])
         && read_data == $past(fifo_out_data[DATA_W-1:0]))
      else $error("tag and data not returned together");

   AST_SPACED_RETURN: assert property (@(posedge ref_clk) disable iff (reset)
      read_data_valid |=> !read_data_valid)
      else $error("returns not spaced");

   AST_FREE_ACCEPTS: assert property (@(posedge ref_clk) disable iff (reset)
      (!s1_valid_r && slot_state_r == SLOT_IDLE) |-> txn_accept)
      else $error("idle slave refused a transaction");

   AST_SLOW_TAG_KEPT: assert property (@(posedge ref_clk) disable iff (reset)
      take_slow |=> slot_tag_r == $past(request_tag))
      else $error("slow read tag not kept");

   AST_RESET_QUIET: assert property (@(posedge ref_clk)
      reset |=> !read_data_valid)
      else $error("return valid after reset");
endmodule // tsb_slave

/* File: tsb_slave_tb.sv */
// self-checking bench for the tagged split transaction slave
`timescale 1ns/1ns
module tsb_slave_tb;
   import tsb_pkg::*;
   typedef struct {
      logic [ADDR_W-1:0] a;
      logic [BE_W-1:0] be_n;
      logic [DATA_W-1:0] d;
      logic [DATA_W-1:0] exp;
   } tsb_row_s;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic txn_valid, op_type_alt, txn_accept, read_data_valid;
   logic [ADDR_W-1:0] address;
   logic [BE_W-1:0] byte_lane_enables_n;
   logic [TAG_W-1:0] request_tag, response_tag;
   logic [DATA_W-1:0] write_data, read_data;
   int err_total = 0;
   int samples_checked = 0;
   int n_resp = 0;
   int t0, r0;
   tsb_row_s rows[6] = '{
      '{45'h08, 8'hfe, 64'hffff_ffff_ffff_ffaa, 64'h0101_0101_0101_01aa},
      '{45'h12, 8'hf3, 64'h0000_0000_bbcc_0000, 64'h0202_0202_bbcc_0202},
      '{45'h1c, 8'h0f, 64'hdead_beef_0000_0000, 64'hdead_beef_0303_0303},
      '{45'h20, 8'h00, 64'h0123_4567_89ab_cdef, 64'h0123_4567_89ab_cdef},
      '{45'h28, 8'hff, 64'hffff_ffff_ffff_ffff, 64'h0505_0505_0505_0505},
      '{45'h37, 8'h7f, 64'h9900_0000_0000_0000, 64'h9906_0606_0606_0606}};
   tsb_slave tsb_slave_i (.ref_clk, .reset, .txn_valid, .op_type_alt, .address,
      .byte_lane_enables_n, .request_tag, .write_data, .txn_accept,
      .read_data_valid, .response_tag, .read_data);
   tsb_master_model tsb_master_model_i (.ref_clk, .txn_valid, .op_type_alt,
      .address, .byte_lane_enables_n, .request_tag, .write_data, .txn_accept,
      .read_data_valid, .response_tag, .read_data);
   always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (err_total == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // write data driven as garbage on reads
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [TAG_W-1:0] t);
      tsb_master_model_i.issue(OP_READ, a, 8'h00, t, ~64'h0);
   endtask
   task automatic expect_resp(input logic [TAG_W-1:0] t, input logic [DATA_W-1:0] exp);
      int k;
      k = 0;
      n_resp++;
      while (tsb_master_model_i.tag_q.size() < n_resp && k < 200) begin
         @(posedge ref_clk);
         k++;
      end
      @(posedge ref_clk);
      #1;
      check(64'(tsb_master_model_i.tag_q[n_resp-1]), 64'(t));
      check(tsb_master_model_i.got[t], exp);
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      #1;
      reset = 1'b0;
      for (int i = 0; i < MEM_WORDS; i++) begin
         tsb_master_model_i.issue(OP_WRITE, 45'(i * 8), 8'h00, 21'h0, {8{8'(i)}});
      end
      tsb_master_model_i.release_bus();
      foreach (rows[i]) begin
         tsb_master_model_i.issue(OP_WRITE, rows[i].a, rows[i].be_n, 21'h0, rows[i].d);
         tsb_master_model_i.release_bus();
         rd(rows[i].a, 21'(i + 1));
         tsb_master_model_i.release_bus();
         expect_resp(21'(i + 1), rows[i].exp);
      end
      reset = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      check(64'(read_data_valid), 64'h0);
      check(64'(response_tag), 64'h0);
      check(read_data, 64'h0);
      check(64'(txn_accept), 64'h1);
      reset = 1'b0;
      rd(45'h20, 21'h40);
      t0 = tsb_master_model_i.take_cyc;
      tsb_master_model_i.release_bus();
      expect_resp(21'h40, rows[3].exp);
      check(64'(tsb_master_model_i.resp_cyc[n_resp-1] - t0), 64'h3);
      rd(45'h120, 21'h50);
      rd(45'h18, 21'h51);
      tsb_master_model_i.release_bus();
      expect_resp(21'h51, rows[2].exp);
      expect_resp(21'h50, rows[3].exp);
      rd(45'h108, 21'h60);
      t0 = tsb_master_model_i.take_cyc;
      rd(45'h110, 21'h61);
      check(64'(tsb_master_model_i.take_cyc - t0 >= 3), 64'h1);
      tsb_master_model_i.release_bus();
      expect_resp(21'h60, rows[0].exp);
      expect_resp(21'h61, rows[1].exp);
      r0 = tsb_master_model_i.refused;
      for (int i = 22; i < 32; i++) rd(45'(i * 8), 21'(i));
      tsb_master_model_i.release_bus();
      check(64'(tsb_master_model_i.refused > r0), 64'h1);
      for (int i = 22; i < 32; i++) expect_resp(21'(i), {8{8'(i)}});
      // full write, then same word read fast and slow back to back
      tsb_master_model_i.issue(OP_WRITE, 45'h20, 8'h00, 21'h0, 64'h5a5a_0f0f_1234_abcd);
      rd(45'h20, 21'h70);
      rd(45'h120, 21'h71);
      tsb_master_model_i.release_bus();
      expect_resp(21'h70, 64'h5a5a_0f0f_1234_abcd);
      expect_resp(21'h71, 64'h5a5a_0f0f_1234_abcd);
      check(64'(8'(tsb_master_model_i.got[21'h6] >> (8 * rows[5].a[2:0]))), 64'h99);
      end_of_test();
   end
   initial begin
      #(3000 * CLK_PERIOD_NS);
      err_total++;
      end_of_test();
   end
endmodule // tsb_slave_tb
